// ==== design/dcc_top.sv ====
module dcc_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [dcc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dcc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] cmpRaw,
  output dcc_pkg::dcc_route_t analogRoute,
  output logic [1:0] cmpPinOut,
  output logic [1:0] cmpPinOe,
  output logic [5:0] portADirection,
  output logic irq
);

  dcc_pkg::dcc_ctrl_t ctrlQ;
  dcc_pkg::dcc_route_t routeD;
  dcc_pkg::dcc_route_t routeQ;
  logic [5:0] portDirQ;
  logic maskQ;
  logic flagQ;
  logic [1:0] syncQ1;
  logic [1:0] syncQ2;
  logic [1:0] cmpOn;
  logic [1:0] result;
  logic [1:0] latchedQ;
  logic [1:0] pinOutQ;
  logic [1:0] pinOeQ;

  logic awHeldQ;
  logic wHeldQ;
  logic [dcc_pkg::AXI_AW-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic wStrb0Q;
  logic bValidQ;
  logic [1:0] bRespQ;
  logic rValidQ;
  logic [31:0] rDataQ;
  logic [1:0] rRespQ;
  logic doWrite;
  logic doRead;
  logic ctrlTouch;

  function automatic dcc_pkg::dcc_route_t route_of(
    input logic [2:0] mode,
    input logic swap
  );
    dcc_pkg::dcc_route_t r;
    r = dcc_pkg::ROUTE_RESET;
    unique case (mode)
      dcc_pkg::MODE_ANALOG, dcc_pkg::MODE_OFF: begin
        r.c1On = 1'b0;
        r.c2On = 1'b0;
      end
      dcc_pkg::MODE_ONE_C1: begin
        r.c1On = 1'b1;
        r.c1Neg = dcc_pkg::SEL_PIN0;
        r.c1Pos = dcc_pkg::SEL_PIN3;
      end
      dcc_pkg::MODE_ONE_C2: begin
        r.c2On = 1'b1;
        r.c2Neg = dcc_pkg::SEL_PIN1;
        r.c2Pos = dcc_pkg::SEL_PIN2;
      end
      dcc_pkg::MODE_TWO_IND, dcc_pkg::MODE_TWO_OUT: begin
        r.c1On = 1'b1;
        r.c2On = 1'b1;
        r.c1Neg = dcc_pkg::SEL_PIN0;
        r.c1Pos = dcc_pkg::SEL_PIN3;
        r.c2Neg = dcc_pkg::SEL_PIN1;
        r.c2Pos = dcc_pkg::SEL_PIN2;
      end
      dcc_pkg::MODE_COMMON: begin
        r.c1On = 1'b1;
        r.c2On = 1'b1;
        r.c1Neg = dcc_pkg::SEL_PIN0;
        r.c1Pos = dcc_pkg::SEL_PIN2;
        r.c2Neg = dcc_pkg::SEL_PIN1;
        r.c2Pos = dcc_pkg::SEL_PIN2;
      end
      dcc_pkg::MODE_MUX_REF: begin
        r.c1On = 1'b1;
        r.c2On = 1'b1;
        r.c1Pos = dcc_pkg::SEL_VREF;
        r.c2Pos = dcc_pkg::SEL_VREF;
        r.c1Neg = swap ? dcc_pkg::SEL_PIN3 : dcc_pkg::SEL_PIN0;
        r.c2Neg = swap ? dcc_pkg::SEL_PIN2 : dcc_pkg::SEL_PIN1;
      end
    endcase
    return r;
  endfunction

  // Register bus handshakes.
  assign s_axi_awready = !awHeldQ;
  assign s_axi_wready = !wHeldQ;
  assign s_axi_arready = !rValidQ;
  assign s_axi_bvalid = bValidQ;
  assign s_axi_bresp = bRespQ;
  assign s_axi_rvalid = rValidQ;
  assign s_axi_rdata = rDataQ;
  assign s_axi_rresp = rRespQ;
  assign doWrite = awHeldQ && wHeldQ && !bValidQ;
  assign doRead = s_axi_arvalid && !rValidQ;
  assign ctrlTouch = (doWrite && awAddrQ == dcc_pkg::OFS_CONTROL)
    || (doRead && s_axi_araddr == dcc_pkg::OFS_CONTROL);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awHeldQ <= 1'b0;
      awAddrQ <= '0;
    end else if (s_axi_awvalid && !awHeldQ) begin
      awHeldQ <= 1'b1;
      awAddrQ <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wHeldQ <= 1'b0;
      wDataQ <= '0;
      wStrb0Q <= 1'b0;
    end else if (s_axi_wvalid && !wHeldQ) begin
      wHeldQ <= 1'b1;
      wDataQ <= s_axi_wdata;
      wStrb0Q <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bValidQ <= 1'b0;
      bRespQ <= dcc_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bValidQ <= 1'b1;
      bRespQ <= (awAddrQ[1:0] == 2'h0 && awAddrQ <= dcc_pkg::OFS_PORT_DIR)
        ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValidQ <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rValidQ <= 1'b0;
      rDataQ <= '0;
      rRespQ <= dcc_pkg::RESP_OKAY;
    end else if (doRead) begin
      rValidQ <= 1'b1;
      rRespQ <= dcc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        dcc_pkg::OFS_CONTROL: rDataQ <= {24'h000000, result, ctrlQ};
        dcc_pkg::OFS_IRQ_STATUS: rDataQ <= {31'h00000000, flagQ};
        dcc_pkg::OFS_IRQ_MASK: rDataQ <= {31'h00000000, maskQ};
        dcc_pkg::OFS_PORT_DIR: rDataQ <= {26'h0000000, portDirQ};
        default: begin
          rDataQ <= '0;
          rRespQ <= dcc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rValidQ <= 1'b0;
    end
  end

  // Only the low byte lane carries register bits; results are read-only.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrlQ <= dcc_pkg::CTRL_RESET;
    end else if (doWrite && wStrb0Q && awAddrQ == dcc_pkg::OFS_CONTROL) begin
      ctrlQ <= dcc_pkg::dcc_ctrl_t'(wDataQ[5:0]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      portDirQ <= dcc_pkg::PORT_DIR_RESET;
      maskQ <= dcc_pkg::IRQ_MASK_RESET;
    end else if (doWrite && wStrb0Q) begin
      if (awAddrQ == dcc_pkg::OFS_PORT_DIR) begin
        portDirQ <= wDataQ[5:0];
      end
      if (awAddrQ == dcc_pkg::OFS_IRQ_MASK) begin
        maskQ <= wDataQ[dcc_pkg::BIT_CHANGE];
      end
    end
  end

  // Route is registered so the analog switches never see decode glitches.
  assign routeD = route_of(ctrlQ.mode, ctrlQ.swap);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      routeQ <= dcc_pkg::ROUTE_RESET;
    end else begin
      routeQ <= routeD;
    end
  end
  assign analogRoute = routeQ;

  // The raw outputs are asynchronous to this clock.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      syncQ1 <= 2'h0;
      syncQ2 <= 2'h0;
    end else begin
      syncQ1 <= cmpRaw;
      syncQ2 <= syncQ1;
    end
  end

  assign cmpOn = {routeQ.c2On, routeQ.c1On};
  // A switched-off comparator reads low whatever its inversion bit.
  assign result[0] = cmpOn[0] & (syncQ2[0] ^ ctrlQ.inv1);
  assign result[1] = cmpOn[1] & (syncQ2[1] ^ ctrlQ.inv2);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      latchedQ <= 2'h0;
    end else if (ctrlTouch) begin
      latchedQ <= result;
    end
  end

  // Mismatch keeps setting the flag; a set in the clear cycle wins.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flagQ <= 1'b0;
    end else if (result != latchedQ) begin
      flagQ <= 1'b1;
    end else if (doWrite && wStrb0Q && awAddrQ == dcc_pkg::OFS_IRQ_STATUS
                 && wDataQ[dcc_pkg::BIT_CHANGE]) begin
      flagQ <= 1'b0;
    end
  end
  assign irq = flagQ & maskQ;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pinOutQ <= 2'h0;
      pinOeQ <= 2'h0;
    end else begin
      pinOutQ <= result;
      pinOeQ[0] <= cmpOn[0] & !portDirQ[dcc_pkg::DIR_BIT_C1];
      pinOeQ[1] <= cmpOn[1] & !portDirQ[dcc_pkg::DIR_BIT_C2];
    end
  end
  assign cmpPinOut = pinOutQ;
  assign cmpPinOe = pinOeQ;
  assign portADirection = portDirQ;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_c1_high;
    (cmpRaw[0])[*2] ##1 (cmpOn[0] && !ctrlQ.inv1) |-> result[0];
  endproperty
  a_c1_high: assert property (p_c1_high)
    else $error("Comparator 1 result not high for a high input.");

  property p_c2_inverted;
    (!cmpRaw[1])[*2] ##1 (cmpOn[1] && ctrlQ.inv2) |-> result[1];
  endproperty
  a_c2_inverted: assert property (p_c2_inverted)
    else $error("Comparator 2 inversion not applied.");

  property p_c1_inverted;
    (cmpRaw[0])[*2] ##1 (cmpOn[0] && ctrlQ.inv1) |-> !result[0];
  endproperty
  a_c1_inverted: assert property (p_c1_inverted)
    else $error("Comparator 1 inversion not applied.");

  property p_reset_state;
    $fell(sys_rst) |-> ctrlQ == dcc_pkg::CTRL_RESET && result == 2'h0;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Control register not at its reset state.");

  property p_swap_route;
    (ctrlQ.mode == dcc_pkg::MODE_MUX_REF && ctrlQ.swap) |=>
      routeQ.c1Neg == dcc_pkg::SEL_PIN3 && routeQ.c2Neg == dcc_pkg::SEL_PIN2;
  endproperty
  a_swap_route: assert property (p_swap_route)
    else $error("Swapped inverting inputs routed wrongly.");

  property p_vref_only_mux;
    routeQ.c1Pos == dcc_pkg::SEL_VREF |->
      $past(ctrlQ.mode) == dcc_pkg::MODE_MUX_REF;
  endproperty
  a_vref_only_mux: assert property (p_vref_only_mux)
    else $error("Internal reference used outside configuration 110.");

  property p_off_mode;
    ctrlQ.mode == dcc_pkg::MODE_OFF |=> cmpOn == 2'h0 && result == 2'h0;
  endproperty
  a_off_mode: assert property (p_off_mode)
    else $error("Comparators not off in configuration 111.");

  property p_mismatch_sets;
    (result != latchedQ) |=> flagQ;
  endproperty
  a_mismatch_sets: assert property (p_mismatch_sets)
    else $error("Output change did not set the change flag.");

  property p_touch_ends;
    ctrlTouch |=> latchedQ == $past(result);
  endproperty
  a_touch_ends: assert property (p_touch_ends)
    else $error("Control access did not end the mismatch.");

  property p_dir_governs;
    portDirQ[dcc_pkg::DIR_BIT_C1] |=> !cmpPinOe[0];
  endproperty
  a_dir_governs: assert property (p_dir_governs)
    else $error("Pin driven while its direction bit says input.");

  property p_pin_follows;
    cmpOn[1] ##1 cmpOn[1] |-> cmpPinOut[1] == $past(result[1]);
  endproperty
  a_pin_follows: assert property (p_pin_follows)
    else $error("Result pin does not follow the result bit.");

  property p_sync_delay;
    $rose(cmpRaw[0]) ##1 (cmpOn[0] && !ctrlQ.inv1) |->
      !result[0];
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Result bypasses the synchroniser.");

endmodule

// ==== inc/dcc_pkg.sv ====
package dcc_pkg;

  localparam int AXI_AW = 5;
  localparam logic [AXI_AW-1:0] OFS_CONTROL = 5'h00;
  localparam logic [AXI_AW-1:0] OFS_IRQ_STATUS = 5'h04;
  localparam logic [AXI_AW-1:0] OFS_IRQ_MASK = 5'h08;
  localparam logic [AXI_AW-1:0] OFS_PORT_DIR = 5'h0C;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bit positions in the control register, and of the change bit in the IRQ status and mask registers.
  localparam int BIT_RES2 = 7;
  localparam int BIT_RES1 = 6;
  localparam int BIT_INV2 = 5;
  localparam int BIT_INV1 = 4;
  localparam int BIT_SWAP = 3;
  localparam int BIT_CHANGE = 0;

  typedef struct packed {
    logic inv2;
    logic inv1;
    logic swap;
    logic [2:0] mode;
  } dcc_ctrl_t;

  localparam dcc_ctrl_t CTRL_RESET = 6'h07;
  localparam logic [5:0] PORT_DIR_RESET = 6'h3F;
  localparam logic IRQ_MASK_RESET = 1'h0;

  localparam logic [2:0] MODE_ANALOG = 3'h0;
  localparam logic [2:0] MODE_ONE_C1 = 3'h1;
  localparam logic [2:0] MODE_TWO_IND = 3'h2;
  localparam logic [2:0] MODE_COMMON = 3'h3;
  localparam logic [2:0] MODE_TWO_OUT = 3'h4;
  localparam logic [2:0] MODE_ONE_C2 = 3'h5;
  localparam logic [2:0] MODE_MUX_REF = 3'h6;
  localparam logic [2:0] MODE_OFF = 3'h7;

  // Input selector codes: analog pin index, or the internal reference.
  localparam logic [2:0] SEL_PIN0 = 3'h0;
  localparam logic [2:0] SEL_PIN1 = 3'h1;
  localparam logic [2:0] SEL_PIN2 = 3'h2;
  localparam logic [2:0] SEL_PIN3 = 3'h3;
  localparam logic [2:0] SEL_VREF = 3'h7;

  // Port A direction bits that gate the two result pins.
  localparam int DIR_BIT_C1 = 4;
  localparam int DIR_BIT_C2 = 5;

  typedef struct packed {
    logic c2On;
    logic c1On;
    logic [2:0] c2Pos;
    logic [2:0] c2Neg;
    logic [2:0] c1Pos;
    logic [2:0] c1Neg;
  } dcc_route_t;

  localparam dcc_route_t ROUTE_RESET = 14'h0000;

endpackage

// ==== testbench/dcc_analog_model.sv ====
// Analog side of the block: four pins and the internal reference.
// Levels are plain codes; the bench keeps each compared pair distinct so no tie occurs.
module dcc_analog_model (
  input wire dcc_pkg::dcc_route_t route,
  input wire logic [39:0] levels,
  output logic [1:0] cmpRaw
);
  timeunit 1ns;
  timeprecision 1ns;

  function automatic logic [7:0] lvl(input logic [39:0] lv,
                                     input logic [2:0] s);
    return (s == 3'h7) ? lv[39:32] : lv[8*s +: 8];
  endfunction

  // A comparator that is switched off drives low.
  assign cmpRaw[0] = route.c1On &&
    (lvl(levels, route.c1Pos) > lvl(levels, route.c1Neg));
  assign cmpRaw[1] = route.c2On &&
    (lvl(levels, route.c2Pos) > lvl(levels, route.c2Neg));
endmodule

// ==== testbench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] awAddr = 5'h00;
  logic [4:0] arAddr = 5'h00;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'hF;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic [39:0] levels = 40'h0;
  logic awReady, wReady, bValid, arReady, rValid, irq;
  logic [1:0] bResp, rResp, cmpRaw, pinOut, pinOe, resp;
  logic [31:0] rData, rd;
  logic [5:0] portDir;
  dcc_pkg::dcc_route_t route;
  int errors = 0;
  int n_checks = 0;
  int seed = 32'h6A43;

  dcc_top dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .cmpRaw(cmpRaw), .analogRoute(route),
    .cmpPinOut(pinOut), .cmpPinOe(pinOe), .portADirection(portDir),
    .irq(irq)
  );

  dcc_analog_model analog (.route(route), .levels(levels), .cmpRaw(cmpRaw));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready is sampled mid-cycle, where it is stable up to the next edge.
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    int n;
    logic aw, w, b;
    @(posedge clk_sys);
    {awAddr, awValid, wData, wValid, bReady} <= {a, 1'b1, d, 1'b1, 1'b1};
    for (n = 0; n < 64; n++) begin
      @(negedge clk_sys);
      aw = awValid & awReady;
      w = wValid & wReady;
      b = bValid;
      resp = bResp;
      @(posedge clk_sys);
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
      if (b) begin
        bReady <= 1'b0;
        break;
      end
    end
    if (n == 64) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask

  task automatic rd_reg(input logic [4:0] a);
    int n;
    logic ar, r;
    @(posedge clk_sys);
    {arAddr, arValid, rReady} <= {a, 1'b1, 1'b1};
    for (n = 0; n < 64; n++) begin
      @(negedge clk_sys);
      ar = arValid & arReady;
      r = rValid;
      rd = rData;
      resp = rResp;
      @(posedge clk_sys);
      if (ar) arValid <= 1'b0;
      if (r) begin
        rReady <= 1'b0;
        break;
      end
    end
    if (n == 64) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  function automatic dcc_pkg::dcc_route_t masked(input dcc_pkg::dcc_route_t r);
    if (!r.c1On) r.c1Pos = 3'h0;
    if (!r.c1On) r.c1Neg = 3'h0;
    if (!r.c2On) r.c2Pos = 3'h0;
    if (!r.c2On) r.c2Neg = 3'h0;
    return r;
  endfunction

  function automatic dcc_pkg::dcc_route_t exp_route(input logic [2:0] m,
                                                    input logic s);
    dcc_pkg::dcc_route_t r;
    r = {2'h0, 3'h2, 3'h1, 3'h3, 3'h0};
    r.c1On = m inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    r.c2On = m inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    if (m == 3'h3) r.c1Pos = 3'h2;
    if (m == 3'h6) begin
      {r.c1Pos, r.c2Pos} = {3'h7, 3'h7};
      {r.c1Neg, r.c2Neg} = s ? {3'h3, 3'h2} : {3'h0, 3'h1};
    end
    return masked(r);
  endfunction

  function automatic logic [1:0] exp_out(input dcc_pkg::dcc_route_t r,
                                         input logic [5:0] c);
    logic [7:0] p1, n1, p2, n2;
    p1 = (r.c1Pos == 3'h7) ? levels[39:32] : levels[8*r.c1Pos +: 8];
    n1 = levels[8*r.c1Neg +: 8];
    p2 = (r.c2Pos == 3'h7) ? levels[39:32] : levels[8*r.c2Pos +: 8];
    n2 = levels[8*r.c2Neg +: 8];
    return {r.c2On & ((p2 > n2) ^ c[5]), r.c1On & ((p1 > n1) ^ c[4])};
  endfunction

  initial begin
    logic [31:0] r;
    logic [7:0] c;
    logic [5:0] dir;
    dcc_pkg::dcc_route_t er;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle(1);
    chk({18'h0, route}, 32'h0);
    rd_reg(dcc_pkg::OFS_CONTROL);
    chk(rd, 32'h07);
    rd_reg(dcc_pkg::OFS_PORT_DIR);
    chk(rd, 32'h3F);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      for (int k = 0; k < 5; k++) begin
        r = $random(seed);
        levels[8*k +: 8] <= {r[4:0], k[2:0]};
      end
      r = $random(seed);
      c = {r[7:3], i[2:0]};
      dir = r[13:8];
      wr_reg(dcc_pkg::OFS_PORT_DIR, {26'h0, dir});
      wr_reg(dcc_pkg::OFS_CONTROL, {24'h0, c});
      chk({30'h0, resp}, {30'h0, dcc_pkg::RESP_OKAY});
      settle(6);
      er = exp_route(c[2:0], c[3]);
      chk({18'h0, masked(route)}, {18'h0, er});
      chk({30'h0, pinOut}, {30'h0, exp_out(er, c[5:0])});
      chk({30'h0, pinOe},
          {30'h0, er.c2On & ~dir[5], er.c1On & ~dir[4]});
      chk({26'h0, portDir}, {26'h0, dir});
      rd_reg(dcc_pkg::OFS_CONTROL);
      chk({26'h0, rd[5:0]}, {26'h0, c[5:0]});
      chk({30'h0, rd[7:6]}, {30'h0, exp_out(er, c[5:0])});
    end
    $display("configuration test done");
    wr_reg(5'h10, 32'hFF);
    chk({30'h0, resp}, {30'h0, dcc_pkg::RESP_SLVERR});
    wr_reg(5'h02, 32'hFF);
    chk({30'h0, resp}, {30'h0, dcc_pkg::RESP_SLVERR});
    rd_reg(5'h14);
    chk({resp, rd[29:0]}, {dcc_pkg::RESP_SLVERR, 30'h0});
    wr_reg(dcc_pkg::OFS_CONTROL, 32'hC7);
    // A write without the low byte lane must leave the register alone.
    wStrb <= 4'hE;
    wr_reg(dcc_pkg::OFS_CONTROL, 32'h12);
    chk({30'h0, resp}, {30'h0, dcc_pkg::RESP_OKAY});
    wStrb <= 4'hF;
    rd_reg(dcc_pkg::OFS_CONTROL);
    chk(rd, 32'h07);
    $display("bus test done");
    // Both comparators on, both results high before the flag is armed.
    @(posedge clk_sys);
    levels <= 40'h1080802040;
    wr_reg(dcc_pkg::OFS_CONTROL, 32'h02);
    settle(6);
    rd_reg(dcc_pkg::OFS_CONTROL);
    chk(rd, 32'hC2);
    wr_reg(dcc_pkg::OFS_IRQ_STATUS, 32'h1);
    wr_reg(dcc_pkg::OFS_IRQ_MASK, 32'h1);
    rd_reg(dcc_pkg::OFS_IRQ_STATUS);
    chk({irq, rd[30:0]}, 32'h0);
    @(posedge clk_sys);
    levels <= 40'h1008802040;
    settle(6);
    chk({31'h0, irq}, 32'h1);
    wr_reg(dcc_pkg::OFS_IRQ_STATUS, 32'h1);
    rd_reg(dcc_pkg::OFS_IRQ_STATUS);
    chk(rd, 32'h1);
    rd_reg(dcc_pkg::OFS_CONTROL);
    chk(rd, 32'h82);
    wr_reg(dcc_pkg::OFS_IRQ_STATUS, 32'h1);
    rd_reg(dcc_pkg::OFS_IRQ_STATUS);
    chk({irq, rd[30:0]}, 32'h0);
    wr_reg(dcc_pkg::OFS_IRQ_MASK, 32'h0);
    @(posedge clk_sys);
    levels <= 40'h1080802040;
    settle(6);
    rd_reg(dcc_pkg::OFS_IRQ_STATUS);
    chk({irq, rd[30:0]}, 32'h1);
    $display("change flag test done");
    wr_reg(dcc_pkg::OFS_CONTROL, 32'h3A);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_reg(dcc_pkg::OFS_CONTROL);
    chk({irq, rd[30:0]}, 32'h07);
    $display("second reset test done");
    finish_test();
  end
endmodule
